// ===== threshold_flag_irq_banks.sv
// threshold flag interrupt banks two and three with ahb-lite register slave
`timescale 1ns/1ps
module threshold_flag_irq_banks
  import threshold_flag_irq_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  input  wire logic [FLAG_W-1:0] bank2_threshold_flags_in,
  input  wire logic [FLAG_W-1:0] bank3_threshold_flags_in,
  input  wire logic [FLAG_W-1:0] other_bank_contrib_in,
  output logic      [FLAG_W-1:0] cpu_irq_lines_out,
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // address phase
  // ----------------------------------------------------------------
  wire addr_valid = hsel_in & htrans_in[1] & hready_in;
  wire word_xfer  = (hsize_in == HSIZE_WORD);
  wire wr_accept  = addr_valid & hwrite_in & word_xfer;
  wire rd_accept  = addr_valid & ~hwrite_in;

  logic        wr_phase_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_phase_reg <= 1'b0;
      wr_addr_reg  <= RDATA_RST;
    end else if (hready_in) begin
      wr_phase_reg <= wr_accept;
      wr_addr_reg  <= haddr_in;
    end
  end

  // ----------------------------------------------------------------
  // data phase write strobes
  // ----------------------------------------------------------------
  wire wr_mask2  = wr_phase_reg & addr_hit(wr_addr_reg, BANK2_MASK_ADDR);   // [RL8]
  wire wr_clear2 = wr_phase_reg & addr_hit(wr_addr_reg, BANK2_CLEAR_ADDR);  // [RL8]
  wire wr_mask3  = wr_phase_reg & addr_hit(wr_addr_reg, BANK3_MASK_ADDR);   // [RL8]
  wire wr_clear3 = wr_phase_reg & addr_hit(wr_addr_reg, BANK3_CLEAR_ADDR);  // [RL8]
  wire wr_smask  = wr_phase_reg & addr_hit(wr_addr_reg, IRQ_SMASK_ADDR);
  // event registers take no write strobe at all
  wire wr_event_hit = wr_phase_reg &
                      (addr_hit(wr_addr_reg, BANK2_EVENT_ADDR) | addr_hit(wr_addr_reg, BANK3_EVENT_ADDR));

  // ----------------------------------------------------------------
  // the two banks
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] events2;
  logic [FLAG_W-1:0] events2_next;
  logic [FLAG_W-1:0] mask2_next;
  logic [FLAG_W-1:0] contrib2;
  logic              rise2;
  logic [FLAG_W-1:0] events3;
  logic [FLAG_W-1:0] events3_next;
  logic [FLAG_W-1:0] mask3_next;
  logic [FLAG_W-1:0] contrib3;
  logic              rise3;

  flag_edge_bank u_bank2 (
    .clk_in          (mclk_in),
    .resetn_in       (resetn_in),
    .flags_in        (bank2_threshold_flags_in),
    .mask_we_in      (wr_mask2),
    .clear_we_in     (wr_clear2),
    .wdata_in        (hwdata_in),
    .events_out      (events2),
    .events_next_out (events2_next),
    .mask_next_out   (mask2_next),
    .contrib_out     (contrib2),
    .rise_any_out    (rise2)
  );

  flag_edge_bank u_bank3 (
    .clk_in          (mclk_in),
    .resetn_in       (resetn_in),
    .flags_in        (bank3_threshold_flags_in),
    .mask_we_in      (wr_mask3),
    .clear_we_in     (wr_clear3),
    .wdata_in        (hwdata_in),
    .events_out      (events3),
    .events_next_out (events3_next),
    .mask_next_out   (mask3_next),
    .contrib_out     (contrib3),
    .rise_any_out    (rise3)
  );

  // ----------------------------------------------------------------
  // interrupt line merge
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] lines_reg;
  wire  [FLAG_W-1:0] lines_next = contrib2 | contrib3 | other_bank_contrib_in;  // [RL4] [RL12]

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lines_reg <= MASK_RST;                                                    // [RL11]
    end else begin
      lines_reg <= lines_next;
    end
  end

  assign cpu_irq_lines_out = lines_reg;                                         // [RL4]

  // ----------------------------------------------------------------
  // summary status, mask and level interrupt
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] smask_reg;
  logic              irq_reg;
  wire               rd_status  = rd_accept & addr_hit(haddr_in, IRQ_STATUS_ADDR);
  wire  [STAT_W-1:0] stat_set   = {rise3, rise2};
  // a set in the clearing read cycle survives the clear
  wire  [STAT_W-1:0] status_next = (rd_status ? STAT_RST : status_reg) | stat_set;
  wire  [STAT_W-1:0] smask_next  = wr_smask ? hwdata_in[STAT_W-1:0] : smask_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_reg <= STAT_RST;
      smask_reg  <= STAT_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      smask_reg  <= smask_next;
      irq_reg    <= |(status_next & smask_next);
    end
  end

  assign irq_out = irq_reg;

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  // values returned, except status, are those the registers hold after the current edge,
  // so a read right after a write sees the written value
  wire [31:0] rd_word =
    addr_hit(haddr_in, BANK2_MASK_ADDR)  ? mask2_next   :
    addr_hit(haddr_in, BANK2_EVENT_ADDR) ? events2_next :
    addr_hit(haddr_in, BANK3_MASK_ADDR)  ? mask3_next   :
    addr_hit(haddr_in, BANK3_EVENT_ADDR) ? events3_next :
    addr_hit(haddr_in, IRQ_STATUS_ADDR)  ? {{(32-STAT_W){1'b0}}, status_reg} :
    addr_hit(haddr_in, IRQ_SMASK_ADDR)   ? {{(32-STAT_W){1'b0}}, smask_next} :
    RDATA_RST;                                                                  // [RL10]

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_reg <= RDATA_RST;
    end else if (rd_accept) begin
      hrdata_reg <= rd_word;
    end
  end

  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rise_sets_event;
    @(posedge mclk_in) disable iff (!resetn_in)
    $rose(bank2_threshold_flags_in[1]) |=> events2[1];
  endproperty
  a_rise_sets_event: assert property (p_rise_sets_event) else $error("rise did not set event"); // [RL1]

  property p_rise_sets_event3;
    @(posedge mclk_in) disable iff (!resetn_in)
    $rose(bank3_threshold_flags_in[8]) |=> events3[8];
  endproperty
  a_rise_sets_event3: assert property (p_rise_sets_event3) else $error("bank three rise lost"); // [RL1]

  property p_line_is_and_or;
    @(posedge mclk_in) disable iff (!resetn_in)
    1'b1 |=> (cpu_irq_lines_out == $past(lines_next));
  endproperty
  a_line_is_and_or: assert property (p_line_is_and_or) else $error("line not merged"); // [RL4]

  property p_masked_blocks;
    @(posedge mclk_in) disable iff (!resetn_in)
    (!(mask2_next[8]) && !(mask3_next[8]) && !other_bank_contrib_in[8] && !wr_mask2 && !wr_mask3)
      ##1 (!other_bank_contrib_in[8]) |=> !cpu_irq_lines_out[8];
  endproperty
  a_masked_blocks: assert property (p_masked_blocks) else $error("masked event reached line"); // [RL3]

  property p_enabled_passes;
    @(posedge mclk_in) disable iff (!resetn_in)
    (events2[17] && u_bank2.mask_reg[17]) |=> cpu_irq_lines_out[17];
  endproperty
  a_enabled_passes: assert property (p_enabled_passes) else $error("enabled event missing"); // [RL2]

  property p_line_holds;
    @(posedge mclk_in) disable iff (!resetn_in)
    (cpu_irq_lines_out[16] && (contrib2[16] || contrib3[16] || other_bank_contrib_in[16]))
      |=> cpu_irq_lines_out[16];
  endproperty
  a_line_holds: assert property (p_line_holds) else $error("line dropped early"); // [RL12]

  property p_event_readonly;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_event_hit && !wr_clear2 && events2 == $past(events2) && bank2_threshold_flags_in == 32'h0000_0000)
      |=> (events2 == $past(events2));
  endproperty
  a_event_readonly: assert property (p_event_readonly) else $error("write changed event"); // [RL9]

  property p_clear3_reads_zero;
    @(posedge mclk_in) disable iff (!resetn_in)
    (rd_accept && addr_hit(haddr_in, BANK3_CLEAR_ADDR)) |=> (hrdata_out == RDATA_RST);
  endproperty
  a_clear3_reads_zero: assert property (p_clear3_reads_zero) else $error("clear register readable"); // [RL10]

  property p_clear_write_bank2;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_accept && addr_hit(haddr_in, BANK2_CLEAR_ADDR)) ##1
      (hwdata_in[0] && !(bank2_threshold_flags_in[0] && !$past(bank2_threshold_flags_in[0])))
      |=> !events2[0];
  endproperty
  a_clear_write_bank2: assert property (p_clear_write_bank2) else $error("bank two clear failed"); // [RL5] [RL8]

  property p_mask_readback;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_accept && addr_hit(haddr_in, BANK3_MASK_ADDR)) ##1
      (rd_accept && addr_hit(haddr_in, BANK3_MASK_ADDR))
      |=> (hrdata_out == $past(hwdata_in));
  endproperty
  a_mask_readback: assert property (p_mask_readback) else $error("mask readback wrong"); // [RL8]

  property p_reset_quiet;
    @(posedge mclk_in)
    $rose(resetn_in) |-> (cpu_irq_lines_out == MASK_RST && !irq_out && events2 == EVENT_RST);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset"); // [RL11]

  property p_irq_level;
    @(posedge mclk_in) disable iff (!resetn_in)
    1'b1 |-> (irq_out == |(status_reg & smask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

  property p_status_set_wins;
    @(posedge mclk_in) disable iff (!resetn_in)
    (rd_status && rise2) |=> status_reg[STAT_BANK2];
  endproperty
  a_status_set_wins: assert property (p_status_set_wins) else $error("status set lost on read");

  property p_status_read_clears;
    @(posedge mclk_in) disable iff (!resetn_in)
    (rd_status && !rise3) |=> !status_reg[STAT_BANK3];
  endproperty
  a_status_read_clears: assert property (p_status_read_clears) else $error("status read did not clear");

  // ----------------------------------------------------------------
  // bus, register and line checks
  // ----------------------------------------------------------------
  property p_resp_okay;
    @(posedge mclk_in) disable iff (!resetn_in)
    1'b1 |-> (hreadyout_out && (hresp_out == HRESP_OKAY));
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus not ready or not okay");

  property p_rise2_status;
    @(posedge mclk_in) disable iff (!resetn_in)
    rise2 |=> status_reg[STAT_BANK2];
  endproperty
  a_rise2_status: assert property (p_rise2_status) else $error("bank two rise not in status");

  property p_rise3_status;
    @(posedge mclk_in) disable iff (!resetn_in)
    rise3 |=> status_reg[STAT_BANK3];
  endproperty
  a_rise3_status: assert property (p_rise3_status) else $error("bank three rise not in status");

  property p_mask2_lands;
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_mask2 |=> (u_bank2.mask_reg == $past(hwdata_in));
  endproperty
  a_mask2_lands: assert property (p_mask2_lands) else $error("bank two mask write lost"); // [RL8]

  property p_mask3_lands;
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_mask3 |=> (u_bank3.mask_reg == $past(hwdata_in));
  endproperty
  a_mask3_lands: assert property (p_mask3_lands) else $error("bank three mask write lost"); // [RL8]

  property p_clear3_one;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_clear3 && hwdata_in[0] && !bank3_threshold_flags_in[0])
      |=> !events3[0];
  endproperty
  a_clear3_one: assert property (p_clear3_one) else $error("bank three clear failed"); // [RL5]

  property p_clear2_zero_keeps;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_clear2 && !hwdata_in[17] && events2[17])
      |=> events2[17];
  endproperty
  a_clear2_zero_keeps: assert property (p_clear2_zero_keeps) else $error("zero clear lost event"); // [RL6]

  property p_event3_readonly;
    @(posedge mclk_in) disable iff (!resetn_in)
    (wr_event_hit && !wr_clear3 && (bank3_threshold_flags_in == 32'h0000_0000))
      |=> (events3 == $past(events3));
  endproperty
  a_event3_readonly: assert property (p_event3_readonly) else $error("write changed bank three"); // [RL9]

  property p_event3_sticky;
    @(posedge mclk_in) disable iff (!resetn_in)
    (events3[8] && !wr_clear3) |=> events3[8];
  endproperty
  a_event3_sticky: assert property (p_event3_sticky) else $error("event dropped by itself"); // [RL9]

  property p_line_falls;
    @(posedge mclk_in) disable iff (!resetn_in)
    (!contrib2[16] && !contrib3[16] && !other_bank_contrib_in[16])
      |=> !cpu_irq_lines_out[16];
  endproperty
  a_line_falls: assert property (p_line_falls) else $error("line high with no source"); // [RL12]

  property p_other_passes;
    @(posedge mclk_in) disable iff (!resetn_in)
    other_bank_contrib_in[31] |=> cpu_irq_lines_out[31];
  endproperty
  a_other_passes: assert property (p_other_passes) else $error("other bank not merged"); // [RL4]

  property p_status_read_data;
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_status |=> (hrdata_out == {{(32-STAT_W){1'b0}}, $past(status_reg)});
  endproperty
  a_status_read_data: assert property (p_status_read_data) else $error("status read data wrong");

  property p_clear2_reads_zero;
    @(posedge mclk_in) disable iff (!resetn_in)
    (rd_accept && addr_hit(haddr_in, BANK2_CLEAR_ADDR)) |=> (hrdata_out == RDATA_RST);
  endproperty
  a_clear2_reads_zero: assert property (p_clear2_reads_zero) else $error("bank two clear readable");

endmodule

// ===== threshold_flag_irq_pkg.sv
// constants for the two threshold-flag interrupt banks
// Function
// [RL1] flag rising edge sets its event bit
// [RL2] contribution is event AND mask, bitwise
// [RL3] mask one passes event, zero blocks it
// [RL4] merged contributions drive interrupt lines 118-149
// [RL5] writing one to clear bit clears event
// [RL6] writing zero to clear bit changes nothing
// [RL7] simultaneous set and clear: set wins
// [RL8] bank registers at 0x4002123C and 0x40021248
// [RL9] event register is read-only to software
// [RL10] bank three clear register write-only, resets zero
// [RL11] reset clears all events and masks
// [RL12] each line ORs its masked contributions
package threshold_flag_irq_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_W      = 32;
  localparam int unsigned STAT_W      = 2;
  localparam int unsigned IRQ_LINE_LO = 118;
  localparam int unsigned IRQ_LINE_HI = 149;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] BANK2_MASK_ADDR   = 32'h4002_123C;
  localparam logic [31:0] BANK2_EVENT_ADDR  = 32'h4002_1240;
  localparam logic [31:0] BANK2_CLEAR_ADDR  = 32'h4002_1244;
  localparam logic [31:0] BANK3_MASK_ADDR   = 32'h4002_1248;
  localparam logic [31:0] BANK3_EVENT_ADDR  = 32'h4002_124C;
  localparam logic [31:0] BANK3_CLEAR_ADDR  = 32'h4002_1250;
  localparam logic [31:0] IRQ_STATUS_ADDR   = 32'h4002_1280;
  localparam logic [31:0] IRQ_SMASK_ADDR    = 32'h4002_1284;

  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [31:0]       MASK_RST    = 32'h0000_0000;
  localparam logic [31:0]       EVENT_RST   = 32'h0000_0000;
  localparam logic [31:0]       CLEAR_RST   = 32'h0000_0000;
  localparam logic [31:0]       RDATA_RST   = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STAT_RST    = 2'h0;
  localparam int unsigned       STAT_BANK2  = 0;
  localparam int unsigned       STAT_BANK3  = 1;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

endpackage

// ===== flag_edge_bank.sv
// one bank of 32 rising-edge event bits with mask and clear
`timescale 1ns/1ps
module flag_edge_bank
  import threshold_flag_irq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic [FLAG_W-1:0] flags_in,
  input  wire logic              mask_we_in,
  input  wire logic              clear_we_in,
  input  wire logic [FLAG_W-1:0] wdata_in,
  output logic      [FLAG_W-1:0] events_out,
  output logic      [FLAG_W-1:0] events_next_out,
  output logic      [FLAG_W-1:0] mask_next_out,
  output logic      [FLAG_W-1:0] contrib_out,
  output logic                   rise_any_out
);

  logic [FLAG_W-1:0] prev_reg;
  logic [FLAG_W-1:0] events_reg;
  logic [FLAG_W-1:0] mask_reg;
  wire  [FLAG_W-1:0] rise      = flags_in & ~prev_reg;                // [RL1]
  wire  [FLAG_W-1:0] clr_bits  = clear_we_in ? wdata_in : CLEAR_RST;  // [RL5] [RL6]
  wire  [FLAG_W-1:0] events_next = (events_reg & ~clr_bits) | rise;   // [RL7] [RL9]
  wire  [FLAG_W-1:0] mask_next = mask_we_in ? wdata_in : mask_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_reg   <= EVENT_RST;
      events_reg <= EVENT_RST;                                        // [RL11]
      mask_reg   <= MASK_RST;                                         // [RL11]
    end else begin
      prev_reg   <= flags_in;
      events_reg <= events_next;
      mask_reg   <= mask_next;
    end
  end

  assign events_out      = events_reg;
  assign events_next_out = events_next;
  assign mask_next_out   = mask_next;
  assign contrib_out     = events_reg & mask_reg;                     // [RL2] [RL3]
  assign rise_any_out    = |rise;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire  [FLAG_W-1:0] set_and_clr = rise & clr_bits;
  wire  [FLAG_W-1:0] clr_only    = clr_bits & ~rise;
  wire  [FLAG_W-1:0] kept_bits   = events_reg & ~clr_bits;

  property p_set_wins;
    @(posedge clk_in) disable iff (!resetn_in)
    (|set_and_clr) |=> ((events_reg & $past(set_and_clr)) == $past(set_and_clr));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // [RL7]

  property p_clear_one;
    @(posedge clk_in) disable iff (!resetn_in)
    (|clr_only) |=> ((events_reg & $past(clr_only)) == EVENT_RST);
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear one did not clear"); // [RL5]

  property p_clear_zero;
    @(posedge clk_in) disable iff (!resetn_in)
    clear_we_in |=> ((events_reg & $past(kept_bits)) == $past(kept_bits));
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear zero changed event"); // [RL6]

endmodule

// ===== flag_engine_model.sv
// flag source model standing in for the post-processing engine
`timescale 1ns/1ps
module flag_engine_model
  import threshold_flag_irq_pkg::*;
(
  input  wire logic              clk_in,
  output logic      [FLAG_W-1:0] bank2_flags_out,
  output logic      [FLAG_W-1:0] bank3_flags_out,
  output logic      [FLAG_W-1:0] other_contrib_out
);
  initial begin
    bank2_flags_out = '0;
    bank3_flags_out = '0;
    other_contrib_out = '0;
  end

  // ----------------------------------------------------------------
  // level update, synchronous to the block clock
  // ----------------------------------------------------------------
  task automatic drive(input logic [FLAG_W-1:0] f2, input logic [FLAG_W-1:0] f3, input logic [FLAG_W-1:0] oc);
    @(posedge clk_in);
    bank2_flags_out <= f2;
    bank3_flags_out <= f3;
    other_contrib_out <= oc;
  endtask
endmodule

// ===== threshold_flag_irq_banks_tb.sv
// self-checking bench for the threshold flag interrupt banks
`timescale 1ns/1ps
module threshold_flag_irq_banks_tb
  import threshold_flag_irq_pkg::*;
;
  logic              mclk_in = 1'b0;
  logic              resetn_in;
  logic              hsel_in;
  logic [31:0]       haddr_in;
  logic [1:0]        htrans_in;
  logic              hwrite_in;
  logic [2:0]        hsize_in;
  logic [31:0]       hwdata_in;
  wire  [31:0]       hrdata_out;
  wire               hreadyout_out;
  wire               hresp_out;
  wire  [FLAG_W-1:0] flags2;
  wire  [FLAG_W-1:0] flags3;
  wire  [FLAG_W-1:0] oth;
  wire  [FLAG_W-1:0] cpu_irq_lines_out;
  wire               irq_out;
  int                n_mismatch = 0;
  int                n_tests = 0;
  logic [31:0]       rd;
  logic [31:0]       addrs [8] = '{BANK2_MASK_ADDR, BANK2_EVENT_ADDR, BANK2_CLEAR_ADDR, BANK3_MASK_ADDR,
                                   BANK3_EVENT_ADDR, BANK3_CLEAR_ADDR, IRQ_STATUS_ADDR, IRQ_SMASK_ADDR};

  always #2.5 mclk_in = ~mclk_in;

  threshold_flag_irq_banks i_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .bank2_threshold_flags_in(flags2), .bank3_threshold_flags_in(flags3), .other_bank_contrib_in(oth),
    .cpu_irq_lines_out(cpu_irq_lines_out), .irq_out(irq_out));

  flag_engine_model i_eng (
    .clk_in(mclk_in), .bank2_flags_out(flags2), .bank3_flags_out(flags3), .other_contrib_out(oth));

  // ----------------------------------------------------------------
  // reporting and compares
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t irq got %b expected %b", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // ahb-lite single word transfers
  // ----------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge mclk_in);
    while (hreadyout_out !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        $display("ERROR %0t bus wait ran out", $time);
        end_sim();
      end
      @(posedge mclk_in);
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    hsize_in <= HSIZE_WORD;
    wait_ready();
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    wait_ready();
    rdv = hrdata_out;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd);
    check32(rd, exp);
  endtask

  // write, then read the same word with its address over the write data
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'b10;
    hwrite_in <= 1'b1;
    hsize_in <= HSIZE_WORD;
    wait_ready();
    hwrite_in <= 1'b0;
    hwdata_in <= wd;
    wait_ready();
    htrans_in <= 2'b00;
    wait_ready();
    check32(hrdata_out, exp);
  endtask

  // outputs are registered: let two edges land before looking
  task automatic settle();
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    $display("ERROR %0t run did not finish", $time);
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 32'h0000_0000;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hsize_in = HSIZE_WORD;
    hwdata_in = 32'h0000_0000;
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    foreach (addrs[i]) rd_chk(addrs[i], 32'h0000_0000);
    check32(cpu_irq_lines_out, 32'h0000_0000);
    wr(BANK2_MASK_ADDR, 32'hFFFF_0000);
    wr_rd(BANK3_MASK_ADDR, 32'h0000_00FF, 32'h0000_00FF);
    rd_chk(BANK2_MASK_ADDR, 32'hFFFF_0000);
    rd_chk(BANK3_MASK_ADDR, 32'h0000_00FF);
    wr(BANK2_EVENT_ADDR, 32'hFFFF_FFFF);
    rd_chk(BANK2_EVENT_ADDR, 32'h0000_0000);
    rd_chk(32'h4002_1254, 32'h0000_0000);
    // rising flags in both banks, part of them masked off
    i_eng.drive(32'h0003_0003, 32'h0000_0101, 32'h0000_0000);
    settle();
    check32(cpu_irq_lines_out, 32'h0003_0001);
    rd_chk(BANK2_EVENT_ADDR, 32'h0003_0003);
    rd_chk(BANK3_EVENT_ADDR, 32'h0000_0101);
    check1(irq_out, 1'b0);
    i_eng.drive(32'h0000_0000, 32'h0000_0000, 32'h8000_0000);
    settle();
    check32(cpu_irq_lines_out, 32'h8003_0001);
    rd_chk(BANK2_EVENT_ADDR, 32'h0003_0003);
    wr(BANK2_CLEAR_ADDR, 32'h0000_0000);
    rd_chk(BANK2_EVENT_ADDR, 32'h0003_0003);
    wr(BANK2_CLEAR_ADDR, 32'h0001_0001);
    rd_chk(BANK2_EVENT_ADDR, 32'h0002_0002);
    wr(BANK3_CLEAR_ADDR, 32'h0000_0001);
    rd_chk(BANK3_EVENT_ADDR, 32'h0000_0100);
    settle();
    check32(cpu_irq_lines_out, 32'h8002_0000);
    // clear lands on the same edge as a new rise of bit 1
    fork
      wr(BANK2_CLEAR_ADDR, 32'h0000_0002);
      begin
        @(posedge mclk_in);
        i_eng.drive(32'h0000_0002, 32'h0000_0000, 32'h0000_0000);
      end
    join
    rd_chk(BANK2_EVENT_ADDR, 32'h0002_0002);
    settle();
    check32(cpu_irq_lines_out, 32'h0002_0000);
    // summary interrupt: masked, unmasked, cleared by read
    check1(irq_out, 1'b0);
    wr(IRQ_SMASK_ADDR, 32'h0000_0003);
    settle();
    check1(irq_out, 1'b1);
    rd_chk(IRQ_STATUS_ADDR, 32'h0000_0003);
    settle();
    check1(irq_out, 1'b0);
    rd_chk(IRQ_STATUS_ADDR, 32'h0000_0000);
    // a rise on the edge of the clearing read survives the clear
    fork
      rd_chk(IRQ_STATUS_ADDR, 32'h0000_0000);
      i_eng.drive(32'h0000_0004, 32'h0000_0000, 32'h0000_0000);
    join
    rd_chk(IRQ_STATUS_ADDR, 32'h0000_0001);
    end_sim();
  end
endmodule
